/* File: hw/esp_pipe_ctrl.v */
// Eight-phase instruction pipeline control with fetch queue and hazards
// Notes on behaviour
// - Each instruction passes F1, F2, D1, D2, R1, R2, E, W in order.
// - Up to twelve instructions in flight: one per phase plus four in the fetch queue.
// - Fetch half (F1 to D1) stalls on program not-ready or a full queue.
// - Back half (D2 to W) stalls only on memory not-ready; an empty queue feeds it idle cycles.
// - Out-of-order register access inserts idle cycles.
// - A reader waits until an earlier register write is visible.
// - Wait states freeze the part holding F1, R1 or W.
// - In R1 the operand read address is driven on the data bus.
// - In R2 the data addressed in R1 is captured.
// - Instruction pointer holds address of instruction just in D2.
// - Fetch addresses are placed on the program address bus.
// - Queue fetched words, decode them, pass commands and constants.
// - Repeat loads a counter; next instruction runs once plus count.
// - Branch redirects fetch to a nonsequential address; repeat replays the D2 word.
// - In W the store address goes out with its data.
`timescale 1ns/1ns
`include "esp_pipe_regs.vh"
module esp_pipe_ctrl (
  input wire SYS_CLK_I,
  input wire RSTN_I,
  output wire [`ESP_ADDR_W-1:0] PROG_ADDR_BUS_O,
  output wire PROG_REQ_O,
  input wire [`ESP_INSN_W-1:0] PROG_READ_BUS_I,
  input wire PROG_READY_I,
  output reg [`ESP_ADDR_W-1:0] DATA_RD_ADDR_O,
  output reg DATA_RD_REQ_O,
  input wire [`ESP_DATA_W-1:0] DATA_RD_BUS_I,
  input wire DATA_RD_READY_I,
  output reg [`ESP_ADDR_W-1:0] DATA_WR_ADDR_O,
  output reg [`ESP_DATA_W-1:0] DATA_WR_BUS_O,
  output reg DATA_WR_REQ_O,
  input wire DATA_WR_READY_I,
  output reg [`ESP_ADDR_W-1:0] INSTRUCTION_POINTER_O,
  output reg [3:0] EXEC_CMD_O,
  output reg [`ESP_DATA_W-1:0] EXEC_OPERAND_O,
  output reg EXEC_VALID_O,
  output reg [`ESP_RPT_W-1:0] REPEAT_COUNT_REG_O
);
  // Phase indices: 0 D2, 1 R1, 2 R2, 3 E, 4 W for the back half
  localparam NB = 5;
  reg [`ESP_ADDR_W-1:0] fetch_addr_q;
  reg f1_v_q, f2_v_q, d1_v_q;
  reg [`ESP_ADDR_W-1:0] f2_a_q, d1_a_q;
  reg [`ESP_INSN_W-1:0] d1_i_q;
  reg [NB-1:0] v_q;
  reg [`ESP_INSN_W-1:0] ins_q [0:NB-1];
  reg [`ESP_ADDR_W-1:0] pc_q [0:NB-1];
  reg [`ESP_DATA_W-1:0] opnd_q [0:NB-1];
  reg [`ESP_RPT_W-1:0] rpt_q;
  reg rpt_armed_q;
  reg rd_tk_q;
  reg rd_tk_r2_q;
  wire [`ESP_INSN_W-1:0] q_insn;
  wire [`ESP_ADDR_W-1:0] q_addr;
  wire q_empty, q_full;
  wire mem_wait, back_stall, front_stall, hazard, redirect, issue;
  wire [`ESP_ADDR_W-1:0] redirect_addr;
  wire [3:0] d2_op, d2_src;
  wire replay;
  wire rd_in_r1, rd_in_r2;
  // Memory not-ready stalls only while its request is still open
  assign mem_wait = (DATA_RD_REQ_O && !DATA_RD_READY_I) ||
    (DATA_WR_REQ_O && !DATA_WR_READY_I);
  assign back_stall = mem_wait;
  // Fetch half owns no data port, so data not-ready freezes it only through a full queue
  assign front_stall = PROG_REQ_O && !PROG_READY_I;
  // Read data stands one cycle after acceptance; note where its load is
  assign rd_in_r1 = rd_tk_q && !rd_tk_r2_q;
  assign rd_in_r2 = rd_tk_q && rd_tk_r2_q;
  assign d2_op = q_insn[`ESP_OP_MSB:`ESP_OP_LSB];
  assign d2_src = q_insn[`ESP_SRC_MSB:`ESP_SRC_LSB];
  // Reader in D2 waits while any older writer of its source register is still ahead
  function writes_reg;
    input [`ESP_INSN_W-1:0] w;
    begin
      writes_reg = (w[`ESP_OP_MSB:`ESP_OP_LSB] == `ESP_OP_ALU) ||
        (w[`ESP_OP_MSB:`ESP_OP_LSB] == `ESP_OP_LOAD);
    end
  endfunction
  reg hz;
  integer k;
  always @*
  begin
    hz = 1'b0;
    for (k = 0; k < NB; k = k + 1)
      if (v_q[k] && writes_reg(ins_q[k]) &&
          ins_q[k][`ESP_DST_MSB:`ESP_DST_LSB] == d2_src &&
          (d2_op == `ESP_OP_ALU || d2_op == `ESP_OP_STORE))
        hz = 1'b1;
  end
  assign hazard = hz;
  // A repeat replays the D2 word instead of popping it
  assign replay = rpt_armed_q && rpt_q != {`ESP_RPT_W{1'b0}};
  // A branch waits out a fetch wait state so the fetch address stands
  assign issue = !q_empty && !back_stall && !hazard &&
    !(d2_op == `ESP_OP_BRANCH && front_stall);
  assign redirect = issue && (d2_op == `ESP_OP_BRANCH);
  assign redirect_addr = q_insn[`ESP_ADDR_W-1:0];
  assign PROG_ADDR_BUS_O = fetch_addr_q;
  // No request while the queue is full, else the answered word is lost
  assign PROG_REQ_O = f1_v_q && !q_full;
  esp_fetch_queue u_queue (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .flush_i(redirect),
    .push_i(d1_v_q && !front_stall),
    .push_insn_i(d1_i_q),
    .push_addr_i(d1_a_q),
    .pop_i(issue && !replay),
    .full_o(q_full),
    .empty_o(q_empty),
    .head_insn_o(q_insn),
    .head_addr_o(q_addr)
  );
  // Fetch half: F1, F2, D1; also throttled by a full queue
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      fetch_addr_q <= `ESP_RESET_ADDR;
      f1_v_q <= 1'b0;
      f2_v_q <= 1'b0;
      d1_v_q <= 1'b0;
      f2_a_q <= `ESP_RESET_ADDR;
      d1_a_q <= `ESP_RESET_ADDR;
      d1_i_q <= {`ESP_INSN_W{1'b0}};
    end
    else if (redirect)
    begin
      fetch_addr_q <= redirect_addr;
      f1_v_q <= 1'b1;
      f2_v_q <= 1'b0;
      d1_v_q <= 1'b0;
    end
    else if (!front_stall && !q_full)
    begin
      f1_v_q <= 1'b1;
      if (f1_v_q)
        fetch_addr_q <= fetch_addr_q + 1'b1;
      f2_v_q <= f1_v_q;
      f2_a_q <= fetch_addr_q;
      d1_v_q <= f2_v_q;
      d1_a_q <= f2_a_q;
      d1_i_q <= PROG_READ_BUS_I;
    end
  end
  // Back half: D2, R1, R2, E, W as one shift chain
  genvar g;
  generate
    for (g = 1; g < NB; g = g + 1)
    begin : g_stage
      always @(posedge SYS_CLK_I or negedge RSTN_I)
      begin
        if (!RSTN_I)
        begin
          v_q[g] <= 1'b0;
          ins_q[g] <= {`ESP_INSN_W{1'b0}};
          pc_q[g] <= `ESP_IP_RESET;
        end
        else if (!back_stall)
        begin
          v_q[g] <= v_q[g-1];
          ins_q[g] <= ins_q[g-1];
          pc_q[g] <= pc_q[g-1];
        end
      end
    end
  endgenerate
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      v_q[0] <= 1'b0;
      ins_q[0] <= {`ESP_INSN_W{1'b0}};
      pc_q[0] <= `ESP_IP_RESET;
      INSTRUCTION_POINTER_O <= `ESP_IP_RESET;
      rpt_q <= `ESP_RPT_RESET;
      rpt_armed_q <= 1'b0;
    end
    else if (!back_stall)
    begin
      v_q[0] <= issue;
      ins_q[0] <= q_insn;
      pc_q[0] <= q_addr;
      if (issue)
      begin
        INSTRUCTION_POINTER_O <= q_addr;
        if (d2_op == `ESP_OP_REPEAT)
        begin
          rpt_q <= q_insn[`ESP_RPT_W-1:0];
          rpt_armed_q <= 1'b1;
        end
        else if (replay)
          rpt_q <= rpt_q - 1'b1;
        else
          rpt_armed_q <= 1'b0;
      end
    end
  end
  // Operand capture along the chain; R2 takes the read bus
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      opnd_q[0] <= {`ESP_DATA_W{1'b0}};
      opnd_q[1] <= {`ESP_DATA_W{1'b0}};
      opnd_q[2] <= {`ESP_DATA_W{1'b0}};
      opnd_q[3] <= {`ESP_DATA_W{1'b0}};
      opnd_q[4] <= {`ESP_DATA_W{1'b0}};
    end
    else if (!back_stall)
    begin
      opnd_q[0] <= {12'h000, q_insn[`ESP_IMM_MSB:`ESP_IMM_LSB]};
      opnd_q[1] <= opnd_q[0];
      opnd_q[2] <= rd_in_r1 ? DATA_RD_BUS_I : opnd_q[1];
      opnd_q[3] <= rd_in_r2 ? DATA_RD_BUS_I : opnd_q[2];
      opnd_q[4] <= opnd_q[3];
    end
    // Frozen: keep the one-cycle read data in its load's own slot
    else if (rd_in_r2)
      opnd_q[2] <= DATA_RD_BUS_I;
    else if (rd_in_r1)
      opnd_q[1] <= DATA_RD_BUS_I;
  end
  // Registered bus outputs for the R1 and W phases
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      DATA_RD_ADDR_O <= {`ESP_ADDR_W{1'b0}};
      DATA_RD_REQ_O <= 1'b0;
      DATA_WR_ADDR_O <= {`ESP_ADDR_W{1'b0}};
      DATA_WR_BUS_O <= {`ESP_DATA_W{1'b0}};
      DATA_WR_REQ_O <= 1'b0;
      EXEC_CMD_O <= `ESP_OP_NOP;
      EXEC_OPERAND_O <= {`ESP_DATA_W{1'b0}};
      EXEC_VALID_O <= 1'b0;
      REPEAT_COUNT_REG_O <= `ESP_RPT_RESET;
      rd_tk_q <= 1'b0;
      rd_tk_r2_q <= 1'b0;
    end
    else
    begin
      REPEAT_COUNT_REG_O <= rpt_q;
      rd_tk_q <= DATA_RD_REQ_O && DATA_RD_READY_I;
      rd_tk_r2_q <= !back_stall;
      if (!back_stall)
      begin
        DATA_RD_REQ_O <= v_q[0] &&
          ins_q[0][`ESP_OP_MSB:`ESP_OP_LSB] == `ESP_OP_LOAD;
        DATA_RD_ADDR_O <= opnd_q[0][`ESP_ADDR_W-1:0];
        DATA_WR_REQ_O <= v_q[3] &&
          ins_q[3][`ESP_OP_MSB:`ESP_OP_LSB] == `ESP_OP_STORE;
        DATA_WR_ADDR_O <= {{(`ESP_ADDR_W-`ESP_REG_W){1'b0}},
          ins_q[3][`ESP_DST_MSB:`ESP_DST_LSB]};
        DATA_WR_BUS_O <= opnd_q[3];
        EXEC_VALID_O <= v_q[2];
        EXEC_CMD_O <= ins_q[2][`ESP_OP_MSB:`ESP_OP_LSB];
        EXEC_OPERAND_O <= rd_in_r2 ? DATA_RD_BUS_I : opnd_q[2];
      end
      else
      begin
        // An accepted transfer is not offered twice while frozen
        if (DATA_RD_READY_I)
          DATA_RD_REQ_O <= 1'b0;
        if (DATA_WR_READY_I)
          DATA_WR_REQ_O <= 1'b0;
      end
    end
  end
endmodule // esp_pipe_ctrl

/* File: hw/esp_pipe_regs.vh */
// Constants of the eight-phase pipeline control block
`ifndef ESP_PIPE_REGS_VH
`define ESP_PIPE_REGS_VH
`define ESP_ADDR_W 22
`define ESP_INSN_W 32
`define ESP_DATA_W 32
`define ESP_RPT_W 8
`define ESP_REG_W 4
`define ESP_Q_DEPTH 4
`define ESP_Q_PTR_W 2
`define ESP_Q_CNT_W 3
`define ESP_RESET_ADDR 22'h000000
`define ESP_IP_RESET 22'h000000
`define ESP_RPT_RESET 8'h00
// Instruction word fields
`define ESP_OP_MSB 31
`define ESP_OP_LSB 28
`define ESP_DST_MSB 27
`define ESP_DST_LSB 24
`define ESP_SRC_MSB 23
`define ESP_SRC_LSB 20
`define ESP_IMM_MSB 19
`define ESP_IMM_LSB 0
// Operation codes
`define ESP_OP_NOP 4'h0
`define ESP_OP_ALU 4'h1
`define ESP_OP_LOAD 4'h2
`define ESP_OP_STORE 4'h3
`define ESP_OP_BRANCH 4'h4
`define ESP_OP_REPEAT 4'h5
`endif

/* File: hw/esp_fetch_queue.v */
// Instruction-fetch queue between the fetch and decode halves
`timescale 1ns/1ns
`include "esp_pipe_regs.vh"
module esp_fetch_queue (
  input wire clk_i,
  input wire rstn_i,
  input wire flush_i,
  input wire push_i,
  input wire [`ESP_INSN_W-1:0] push_insn_i,
  input wire [`ESP_ADDR_W-1:0] push_addr_i,
  input wire pop_i,
  output wire full_o,
  output wire empty_o,
  output wire [`ESP_INSN_W-1:0] head_insn_o,
  output wire [`ESP_ADDR_W-1:0] head_addr_o
);
  reg [`ESP_INSN_W-1:0] insn_mem [0:`ESP_Q_DEPTH-1];
  reg [`ESP_ADDR_W-1:0] addr_mem [0:`ESP_Q_DEPTH-1];
  reg [`ESP_Q_PTR_W-1:0] wr_q;
  reg [`ESP_Q_PTR_W-1:0] rd_q;
  reg [`ESP_Q_CNT_W-1:0] cnt_q;
  wire do_push;
  wire do_pop;
  assign full_o = (cnt_q == `ESP_Q_DEPTH);
  assign empty_o = (cnt_q == {`ESP_Q_CNT_W{1'b0}});
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign head_insn_o = insn_mem[rd_q];
  assign head_addr_o = addr_mem[rd_q];
  always @(posedge clk_i)
  begin
    if (do_push)
    begin
      insn_mem[wr_q] <= push_insn_i;
      addr_mem[wr_q] <= push_addr_i;
    end
  end
  // Flush drops stale sequential words fetched past a redirection
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q <= {`ESP_Q_PTR_W{1'b0}};
      rd_q <= {`ESP_Q_PTR_W{1'b0}};
      cnt_q <= {`ESP_Q_CNT_W{1'b0}};
    end
    else if (flush_i)
    begin
      wr_q <= {`ESP_Q_PTR_W{1'b0}};
      rd_q <= {`ESP_Q_PTR_W{1'b0}};
      cnt_q <= {`ESP_Q_CNT_W{1'b0}};
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 1'b1;
      if (do_pop)
        rd_q <= rd_q + 1'b1;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // esp_fetch_queue

/* File: verification/esp_pipe_ctrl_properties.sv */
// Port checks for the eight-phase pipeline control
`timescale 1ns/1ns
module esp_pipe_checker (
  input wire SYS_CLK_I,
  input wire RSTN_I,
  input wire [21:0] PROG_ADDR_BUS_O,
  input wire PROG_REQ_O,
  input wire PROG_READY_I,
  input wire [21:0] DATA_RD_ADDR_O,
  input wire DATA_RD_REQ_O,
  input wire DATA_RD_READY_I,
  input wire [21:0] DATA_WR_ADDR_O,
  input wire [31:0] DATA_WR_BUS_O,
  input wire DATA_WR_REQ_O,
  input wire DATA_WR_READY_I,
  input wire [21:0] INSTRUCTION_POINTER_O,
  input wire [3:0] EXEC_CMD_O,
  input wire EXEC_VALID_O,
  input wire [7:0] REPEAT_COUNT_REG_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence s_release;
    $rose(RSTN_I);
  endsequence
  sequence s_first_fetch;
    !PROG_REQ_O ##1 PROG_REQ_O && PROG_ADDR_BUS_O == 22'h000000;
  endsequence
  a_reset_fetch: assert property (s_release |-> s_first_fetch)
    else $error("first fetch after reset wrong");
  a_fetch_wait: assert property (PROG_REQ_O && !PROG_READY_I |=>
    PROG_REQ_O && $stable(PROG_ADDR_BUS_O))
    else $error("fetch address moved in wait state");
  a_read_wait: assert property (DATA_RD_REQ_O && !DATA_RD_READY_I |=>
    DATA_RD_REQ_O && $stable(DATA_RD_ADDR_O))
    else $error("read address moved in wait state");
  a_write_wait: assert property (DATA_WR_REQ_O && !DATA_WR_READY_I |=>
    DATA_WR_REQ_O && $stable(DATA_WR_ADDR_O) && $stable(DATA_WR_BUS_O))
    else $error("write moved in wait state");
  a_ip_frozen: assert property (DATA_RD_REQ_O && !DATA_RD_READY_I |=>
    $stable(INSTRUCTION_POINTER_O))
    else $error("pointer moved while back half frozen");
  a_exec_frozen: assert property (DATA_WR_REQ_O && !DATA_WR_READY_I |=>
    $stable(EXEC_CMD_O) && $stable(EXEC_VALID_O))
    else $error("execute moved while write waits");
  a_repeat_step: assert property (REPEAT_COUNT_REG_O != 8'h00 |=>
    REPEAT_COUNT_REG_O == $past(REPEAT_COUNT_REG_O) ||
    REPEAT_COUNT_REG_O == $past(REPEAT_COUNT_REG_O) - 8'h01)
    else $error("repeat count jumped");
  a_wr_once: assert property (DATA_WR_REQ_O && DATA_WR_READY_I |=>
    !DATA_WR_REQ_O || $changed(DATA_WR_ADDR_O) || $changed(DATA_WR_BUS_O))
    else $error("accepted write offered again");
endmodule // esp_pipe_checker

/* File: verification/esp_mem_model.sv */
// Program and data memory model with wait states
`timescale 1ns/1ns
module esp_mem_model (
  input wire clk_i,
  input wire [2:0] stall_i,
  input wire [21:0] prog_addr_i,
  input wire prog_req_i,
  output reg [31:0] prog_data_o,
  output wire prog_ready_o,
  input wire [21:0] rd_addr_i,
  input wire rd_req_i,
  output reg [31:0] rd_data_o,
  output wire rd_ready_o,
  output wire wr_ready_o
);
  reg [31:0] prog [0:15];
  // Slow answers come from the bench stall pattern
  assign prog_ready_o = !stall_i[0];
  assign rd_ready_o = !stall_i[1];
  assign wr_ready_o = !stall_i[2];
  initial
  begin
    prog_data_o = 32'h00000000;
    rd_data_o = 32'h00000000;
  end
  always @(posedge clk_i)
  begin
    if (prog_req_i && prog_ready_o)
      prog_data_o <= prog[prog_addr_i[3:0]];
    // Read data stands one cycle after acceptance, then turns to garbage while ready
    if (rd_req_i && rd_ready_o)
      rd_data_o <= {rd_addr_i[15:0] ^ 16'hA5A5, rd_addr_i[15:0]};
    else if (rd_ready_o)
      rd_data_o <= ~rd_data_o;
  end
endmodule // esp_mem_model

/* File: verification/test_eight_stage_pipeline_control.sv */
// Self-checking bench for the eight-phase pipeline control
`timescale 1ns/1ns
`include "esp_pipe_regs.vh"
`define CHK(nm, ex, got) begin n_tests = n_tests + 1; \
  if ((got) !== (ex)) begin bad_count = bad_count + 1; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module test_eight_stage_pipeline_control;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] stall = 3'h0;
  wire [21:0] paddr, raddr, waddr, ip;
  wire [31:0] pdata, rdata, wbus, opnd;
  wire preq, prdy, rreq, rrdy, wreq, wrdy, evld;
  wire [3:0] cmd;
  wire [7:0] rcnt;
  integer seed, bad_count, n_tests, pass, k, nexe, nwr;
  reg [3:0] ecmd [0:6];
  reg [31:0] eop [0:6];
  reg [31:0] rv;
  reg [21:0] wa;
  reg [19:0] im1, im2;
  reg saw8, saw2;
  integer cyc = 0;
  integer ecy [0:6];
  reg [27:0] seq = 28'h2131112;
  always #4 sys_clk = ~sys_clk;
  esp_pipe_ctrl u_esp_pipe_ctrl (.SYS_CLK_I(sys_clk), .RSTN_I(rstn),
    .PROG_ADDR_BUS_O(paddr), .PROG_REQ_O(preq), .PROG_READ_BUS_I(pdata),
    .PROG_READY_I(prdy), .DATA_RD_ADDR_O(raddr), .DATA_RD_REQ_O(rreq),
    .DATA_RD_BUS_I(rdata), .DATA_RD_READY_I(rrdy), .DATA_WR_ADDR_O(waddr),
    .DATA_WR_BUS_O(wbus), .DATA_WR_REQ_O(wreq), .DATA_WR_READY_I(wrdy),
    .INSTRUCTION_POINTER_O(ip), .EXEC_CMD_O(cmd), .EXEC_OPERAND_O(opnd),
    .EXEC_VALID_O(evld), .REPEAT_COUNT_REG_O(rcnt));
  esp_mem_model u_esp_mem_model (.clk_i(sys_clk), .stall_i(stall),
    .prog_addr_i(paddr), .prog_req_i(preq), .prog_data_o(pdata),
    .prog_ready_o(prdy), .rd_addr_i(raddr), .rd_req_i(rreq),
    .rd_data_o(rdata), .rd_ready_o(rrdy), .wr_ready_o(wrdy));
  function [31:0] dmem_f(input [21:0] a);
    dmem_f = {a[15:0] ^ 16'hA5A5, a[15:0]};
  endfunction
  // Count each ALU, load or store execute only once, not while a wait state freezes it
  always @(posedge sys_clk)
    if (rstn)
    begin
      if (evld && cmd >= 4'h1 && cmd <= 4'h3 && !(rreq && !rrdy) &&
        !(wreq && !wrdy) && nexe < 7)
      begin
        ecmd[nexe] <= cmd;
        eop[nexe] <= opnd;
        ecy[nexe] <= cyc;
        nexe <= nexe + 1;
      end
      if (wreq && wrdy)
      begin
        nwr <= nwr + 1;
        wa <= waddr;
      end
      if (preq && prdy && paddr == 22'h000008)
        saw8 <= 1'b1;
      if (rcnt == 8'h02)
        saw2 <= 1'b1;
      cyc <= cyc + 1;
    end
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #40000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial
  begin
    seed = 9902;
    bad_count = 0;
    n_tests = 0;
    // Pass 0 runs prompt, pass 1 stalls at random; each pass starts from reset
    for (pass = 0; pass < 2; pass = pass + 1)
    begin
      rstn = 1'b0;
      nexe = 0;
      nwr = 0;
      saw8 = 1'b0;
      saw2 = 1'b0;
      rv = $random(seed);
      im1 = rv[19:0];
      rv = $random(seed);
      im2 = rv[19:0];
      u_esp_mem_model.prog[0] = {`ESP_OP_LOAD, 8'h10, im1};
      u_esp_mem_model.prog[1] = {`ESP_OP_ALU, 8'h21, 20'h00000};
      u_esp_mem_model.prog[2] = {`ESP_OP_STORE, 8'h32, 20'h00020};
      u_esp_mem_model.prog[3] = {`ESP_OP_REPEAT, 8'h00, 20'h00002};
      u_esp_mem_model.prog[4] = {`ESP_OP_ALU, 8'h56, 20'h00000};
      u_esp_mem_model.prog[5] = {`ESP_OP_BRANCH, 6'h00, 22'h000008};
      u_esp_mem_model.prog[6] = {`ESP_OP_STORE, 8'hF0, 20'h00000};
      u_esp_mem_model.prog[7] = {`ESP_OP_STORE, 8'hF0, 20'h00000};
      u_esp_mem_model.prog[8] = {`ESP_OP_LOAD, 8'h40, im2};
      u_esp_mem_model.prog[9] = {`ESP_OP_BRANCH, 6'h00, 22'h000009};
      for (k = 10; k < 16; k = k + 1)
        u_esp_mem_model.prog[k] = 32'h00000000;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      for (k = 0; k < 600 && nexe < 7; k = k + 1)
      begin
        @(negedge sys_clk);
        rv = $random(seed) & $random(seed);
        stall = (pass == 1) ? rv[2:0] : 3'h0;
      end
      stall = 3'h0;
      repeat (30) @(negedge sys_clk);
      `CHK("exec_count", 7, nexe)
      for (k = 0; k < 7; k = k + 1)
        `CHK("exec_cmd", seq[27-4*k -: 4], ecmd[k])
      `CHK("load_data0", dmem_f({2'b00, im1}), eop[0])
      `CHK("load_data1", dmem_f({2'b00, im2}), eop[6])
      `CHK("store_count", 1, nwr)
      `CHK("store_addr", 22'h000003, wa)
      `CHK("branch_fetch", 1'b1, saw8)
      `CHK("repeat_load", 1'b1, saw2)
      // Reader of the load result may not reach E until the load left W
      `CHK("raw_gap", 1'b1, (ecy[1] - ecy[0] >= 4))
      `CHK("ip_final", 22'h000009, ip)
    end
    print_verdict;
  end
endmodule // test_eight_stage_pipeline_control
bind esp_pipe_ctrl esp_pipe_checker u_esp_pipe_checker (.SYS_CLK_I, .RSTN_I,
  .PROG_ADDR_BUS_O, .PROG_REQ_O, .PROG_READY_I, .DATA_RD_ADDR_O,
  .DATA_RD_REQ_O, .DATA_RD_READY_I, .DATA_WR_ADDR_O, .DATA_WR_BUS_O,
  .DATA_WR_REQ_O, .DATA_WR_READY_I, .INSTRUCTION_POINTER_O, .EXEC_CMD_O,
  .EXEC_VALID_O, .REPEAT_COUNT_REG_O);
